//--- design/sblef_consts.svh
/*
  Offsets, field positions, reset values and timing figures of the
  link event flag block. Assumes a 200 MHz system clock.
*/
`ifndef SBLEF_CONSTS_SVH
`define SBLEF_CONSTS_SVH

// Register word offsets (byte addresses)
`define SBLEF_ADDR_W          8
`define SBLEF_OFS_FLAGS       8'h00
`define SBLEF_OFS_MASK        8'h04
`define SBLEF_OFS_CTRL        8'h08
`define SBLEF_OFS_FLUSH       8'h0C
`define SBLEF_OFS_STATUS      8'h10

// Event flag bit positions
`define SBLEF_BIT_SELF_ID     4
`define SBLEF_BIT_TX_IDLE     5
`define SBLEF_BIT_RX_BLOCK    6
`define SBLEF_BIT_RST_CMD     7
`define SBLEF_BIT_ACK_RCV     8
`define SBLEF_BIT_ISO_FMT     11
`define SBLEF_BIT_ASYNC_FMT   12
`define SBLEF_BIT_BUSY_ACK    14
`define SBLEF_BIT_HDR_CRC     15
`define SBLEF_BIT_TCODE       16
`define SBLEF_BIT_CYC_OVR     19
`define SBLEF_FLAGS_IMPL      32'h0009_D9F0

// Control and other field positions
`define SBLEF_BIT_SID_CAPT    1
`define SBLEF_BIT_TRIG_SPLIT  2
`define SBLEF_BIT_FLUSH       0
`define SBLEF_BIT_ST_ERR      0
`define SBLEF_BIT_ST_IDLE     1

// Reset values
`define SBLEF_RST_FLAGS       32'h0000_0000
`define SBLEF_RST_MASK        32'h0000_0000
`define SBLEF_RST_CTRL        32'h0000_0002

// Timing
`define SBLEF_CLK_MHZ         200
`define SBLEF_ACK_TMO_NS      1000
`define SBLEF_ACK_TMO_CYC     ((`SBLEF_ACK_TMO_NS * `SBLEF_CLK_MHZ) / 1000)
`define SBLEF_CYC_OVR_NS      125000
`define SBLEF_CYC_OVR_CYC     ((`SBLEF_CYC_OVR_NS * `SBLEF_CLK_MHZ) / 1000)

`endif

//--- design/sblef_cycle_watchdog.sv
/*
  Isochronous cycle length watchdog: one pulse when a cycle runs
  past its limit. Assumes cycle_active is a same-clock level.
*/
`timescale 1ns/1ps
`include "sblef_consts.svh"

module sblef_cycle_watchdog #(
  parameter int LIMIT = `SBLEF_CYC_OVR_CYC
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Cycle state
  input  wire logic cycle_active,
  output logic      overrun_q
);

  localparam int CW = $clog2(LIMIT + 1);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] cnt_q;
  logic          fired_q;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else if (!cycle_active) begin
      cnt_q <= '0;
    end else if (cnt_q != LIM) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // One pulse per cycle, however long it overruns
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      fired_q   <= 1'b0;
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= cycle_active && cnt_q == LIM && !fired_q; // [RULE15]
      if (!cycle_active) begin
        fired_q <= 1'b0;
      end else if (cnt_q == LIM) begin
        fired_q <= 1'b1;
      end
    end
  end

  chk_overrun_limit : assert property (@(posedge sys_clk) // [RULE15]
    disable iff (!reset_n)
    $rose(overrun_q) |-> $past(cycle_active) && $past(cnt_q) == LIM)
    else $error("overrun flagged before the cycle limit");

endmodule : sblef_cycle_watchdog

//--- design/sblef_event_flags.sv
/*
  Link event flags of a serial-bus link controller, with the async
  transmit sequencer that raises three of them, mask, interrupt and a
  plain register port. Assumes all event inputs come from same-clock
  datapath logic as one-cycle pulses unless noted as levels.

  // Overview of operation
  // RULE1: Missing ack on non-broadcast send counts as lost arbitration; rearbitrate.
  // RULE2: Set receive-block flag per stored block; whole packet when splitting off.
  // RULE3: During self-ID phase, receive-block flag waits until bus reset completes.
  // RULE4: Quadlet write to the reset-start register sets reset-command flag.
  // RULE5: Ack arrival or ack timeout after async send sets ack-received flag.
  // RULE6: Software sets a mask bit to let a flag raise the interrupt.
  // RULE7: Invalid data at isochronous transmit queue sets iso format-error flag.
  // RULE8: First quadlet not via first-quadlet port: error state, async format flag.
  // RULE9: Async queue underflow during send: error state, async format flag.
  // RULE10: Error state sends no async packet until software flushes the queue.
  // RULE11: Isochronous transmission continues normally during async error state.
  // RULE12: Receive queue overflow: busy-ack addressed packets, set busy-ack flag.
  // RULE13: Header CRC error on possibly ours packet: discard it, set flag.
  // RULE14: Invalid transaction code from transmit queue sets code-error flag.
  // RULE15: Isochronous cycle longer than 125 us sets cycle-overrun flag.
  // RULE16: Bus reset done with self-ID capture on sets self-ID-done flag.
  // RULE17: Transmitter becoming idle and ready sets transmitter-ready flag.
  // RULE18: Flags stay set until software clears them by reading.
*/
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "sblef_consts.svh"

module sblef_event_flags #(
  parameter int CYC_OVR_CYC = `SBLEF_CYC_OVR_CYC,
  parameter int ACK_TMO_CYC = `SBLEF_ACK_TMO_CYC
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // Register port
  input  wire logic [`SBLEF_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata_q,
  output logic                          irq_q,
  // Async transmitter
  input  wire logic                     async_pkt_ready,
  input  wire logic                     first_quadlet_port,
  input  wire logic                     async_broadcast,
  input  wire logic                     bus_idle,
  input  wire logic                     arb_won,
  input  wire logic                     send_done,
  input  wire logic                     async_underflow,
  input  wire logic                     ack_valid_bit,
  output logic                          async_arb_req_q,
  output logic                          async_send_q,
  output logic                          async_queue_flush_q,
  // Iso transmitter
  input  wire logic                     iso_pkt_ready,
  input  wire logic                     iso_bad_data,
  input  wire logic                     tx_bad_tcode,
  input  wire logic                     iso_cycle_active,
  output logic                          iso_tx_start_q,
  // Receiver
  input  wire logic                     rx_packet_end,
  input  wire logic                     rx_trigger_hit,
  input  wire logic                     rx_quadlet_write,
  input  wire logic                     rx_dest_reset_start,
  input  wire logic                     rx_addressed,
  input  wire logic                     queue_overflow,
  input  wire logic                     rx_hdr_crc_err,
  input  wire logic                     rx_maybe_ours,
  input  wire logic                     bus_reset_active,
  input  wire logic                     bus_reset_done,
  output logic                          busy_ack_q,
  output logic                          rx_discard_q
);

  localparam int TW = $clog2(ACK_TMO_CYC + 1);
  localparam logic [TW-1:0] TMO = TW'(ACK_TMO_CYC - 1);

  // Local state names, since nothing is imported from the package
  localparam sblef_pkg::sblef_tx_state_e TX_IDLE     = sblef_pkg::TX_IDLE;
  localparam sblef_pkg::sblef_tx_state_e TX_ARB      = sblef_pkg::TX_ARB;
  localparam sblef_pkg::sblef_tx_state_e TX_SEND     = sblef_pkg::TX_SEND;
  localparam sblef_pkg::sblef_tx_state_e TX_WAIT_ACK = sblef_pkg::TX_WAIT_ACK;
  localparam sblef_pkg::sblef_tx_state_e TX_ERROR    = sblef_pkg::TX_ERROR;

  sblef_pkg::sblef_tx_state_e state_q;
  sblef_pkg::sblef_tx_state_e state_d;
  sblef_pkg::sblef_word_t     flags_q;
  sblef_pkg::sblef_word_t     mask_q;
  sblef_pkg::sblef_word_t     ctrl_q;
  sblef_pkg::sblef_word_t     events;
  logic [TW-1:0]              tmo_cnt_q;
  logic                       tmo_hit;
  logic                       was_idle_q;
  logic                       rx_pend_q;
  logic                       ev_rx_block;
  logic                       ev_overrun;
  logic                       flush_wr;
  logic                       flags_rd;

  assign flush_wr = reg_wr && reg_addr == `SBLEF_OFS_FLUSH
                    && reg_wdata[`SBLEF_BIT_FLUSH];
  assign flags_rd = reg_rd && reg_addr == `SBLEF_OFS_FLAGS;
  assign tmo_hit  = tmo_cnt_q == TMO;
  // A block is a whole packet unless trigger splitting is on
  assign ev_rx_block = rx_packet_end
                       || (ctrl_q[`SBLEF_BIT_TRIG_SPLIT]
                           && rx_trigger_hit); // [RULE2]

  sblef_cycle_watchdog #(
    .LIMIT        (CYC_OVR_CYC)
  ) u_watchdog (
    .sys_clk      (sys_clk),
    .reset_n      (reset_n),
    .cycle_active (iso_cycle_active),
    .overrun_q    (ev_overrun)
  );

  // Async transmit sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      TX_IDLE: begin
        if (async_pkt_ready) begin
          state_d = first_quadlet_port ? TX_ARB : TX_ERROR; // [RULE8]
        end
      end
      TX_ARB: begin
        if (bus_idle && arb_won) begin
          state_d = TX_SEND;
        end
      end
      TX_SEND: begin
        if (async_underflow) begin
          state_d = TX_ERROR; // [RULE9]
        end else if (send_done) begin
          state_d = async_broadcast ? TX_IDLE : TX_WAIT_ACK;
        end
      end
      TX_WAIT_ACK: begin
        if (ack_valid_bit) begin
          state_d = TX_IDLE;
        end else if (tmo_hit) begin
          state_d = TX_ARB; // [RULE1]
        end
      end
      TX_ERROR: begin
        if (flush_wr) begin
          state_d = TX_IDLE; // [RULE10]
        end
      end
      default: state_d = TX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_q <= TX_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || state_q != TX_WAIT_ACK) begin
      tmo_cnt_q <= '0;
    end else if (!tmo_hit) begin
      tmo_cnt_q <= tmo_cnt_q + TW'(1);
    end
  end

  // Transmit side strobes
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      async_arb_req_q     <= 1'b0;
      async_send_q        <= 1'b0;
      async_queue_flush_q <= 1'b0;
      iso_tx_start_q      <= 1'b0;
      was_idle_q          <= 1'b0;
    end else begin
      // Wait for an idle bus before each attempt
      async_arb_req_q     <= state_d == TX_ARB; // [RULE1]
      async_send_q        <= state_d == TX_SEND; // [RULE10]
      async_queue_flush_q <= flush_wr;
      iso_tx_start_q      <= iso_pkt_ready; // [RULE11]
      was_idle_q          <= state_q == TX_IDLE;
    end
  end

  // Receiver answers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      busy_ack_q   <= 1'b0;
      rx_discard_q <= 1'b0;
    end else begin
      busy_ack_q   <= rx_addressed && queue_overflow; // [RULE12]
      rx_discard_q <= rx_hdr_crc_err && rx_maybe_ours; // [RULE13]
    end
  end

  // Blocks seen during the self-ID phase are held back
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rx_pend_q <= 1'b0;
    end else if (bus_reset_done) begin
      rx_pend_q <= 1'b0;
    end else if (bus_reset_active && ev_rx_block) begin
      rx_pend_q <= 1'b1; // [RULE3]
    end
  end

  always_comb begin
    events = '0;
    events[`SBLEF_BIT_SELF_ID]   = bus_reset_done
                                   && ctrl_q[`SBLEF_BIT_SID_CAPT]; // [RULE16]
    events[`SBLEF_BIT_TX_IDLE]   = state_q == TX_IDLE && !was_idle_q; // [RULE17]
    events[`SBLEF_BIT_RX_BLOCK]  = (ev_rx_block && !bus_reset_active)
                                   || (bus_reset_done
                                       && (rx_pend_q || ev_rx_block)); // [RULE3]
    events[`SBLEF_BIT_RST_CMD]   = rx_quadlet_write
                                   && rx_dest_reset_start; // [RULE4]
    events[`SBLEF_BIT_ACK_RCV]   = state_q == TX_WAIT_ACK
                                   && (ack_valid_bit || tmo_hit); // [RULE5]
    events[`SBLEF_BIT_ISO_FMT]   = iso_bad_data; // [RULE7]
    events[`SBLEF_BIT_ASYNC_FMT] = state_q != TX_ERROR
                                   && state_d == TX_ERROR; // [RULE8] [RULE9]
    events[`SBLEF_BIT_BUSY_ACK]  = rx_addressed && queue_overflow; // [RULE12]
    events[`SBLEF_BIT_HDR_CRC]   = rx_hdr_crc_err && rx_maybe_ours; // [RULE13]
    events[`SBLEF_BIT_TCODE]     = tx_bad_tcode; // [RULE14]
    events[`SBLEF_BIT_CYC_OVR]   = ev_overrun; // [RULE15]
  end

  // Sticky flags; a set in the clearing read survives it
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      flags_q <= `SBLEF_RST_FLAGS;
    end else if (flags_rd) begin
      flags_q <= events; // [RULE18]
    end else begin
      flags_q <= flags_q | events; // [RULE18]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mask_q <= `SBLEF_RST_MASK;
      ctrl_q <= `SBLEF_RST_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == `SBLEF_OFS_MASK) begin
        mask_q <= reg_wdata & `SBLEF_FLAGS_IMPL;
      end
      if (reg_addr == `SBLEF_OFS_CTRL) begin
        ctrl_q <= '0;
        ctrl_q[`SBLEF_BIT_SID_CAPT]   <= reg_wdata[`SBLEF_BIT_SID_CAPT];
        ctrl_q[`SBLEF_BIT_TRIG_SPLIT] <= reg_wdata[`SBLEF_BIT_TRIG_SPLIT];
      end
    end
  end

  // Masked flags drive the interrupt level
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags_q & mask_q); // [RULE6]
    end
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!reset_n || !reg_rd) begin
      reg_rdata_q <= '0;
    end else begin
      unique case (reg_addr)
        `SBLEF_OFS_FLAGS: reg_rdata_q <= flags_q;
        `SBLEF_OFS_MASK:  reg_rdata_q <= mask_q;
        `SBLEF_OFS_CTRL:  reg_rdata_q <= ctrl_q;
        `SBLEF_OFS_STATUS: begin
          reg_rdata_q <= '0;
          reg_rdata_q[`SBLEF_BIT_ST_ERR]  <= state_q == TX_ERROR;
          reg_rdata_q[`SBLEF_BIT_ST_IDLE] <= state_q == TX_IDLE;
        end
        default: reg_rdata_q <= '0;
      endcase
    end
  end

  chk_rearb_on_tmo : assert property (@(posedge sys_clk) // [RULE1]
    disable iff (!reset_n)
    state_q == TX_WAIT_ACK && !ack_valid_bit && tmo_hit
    |=> state_q == TX_ARB && async_arb_req_q && !async_send_q)
    else $error("no rearbitration after missing ack");

  chk_rx_block_flag : assert property (@(posedge sys_clk) // [RULE2]
    disable iff (!reset_n)
    rx_packet_end && !bus_reset_active |=> flags_q[`SBLEF_BIT_RX_BLOCK])
    else $error("stored packet did not set the receive flag");

  chk_sid_defer : assert property (@(posedge sys_clk) // [RULE3]
    disable iff (!reset_n)
    bus_reset_active && !bus_reset_done && ev_rx_block && !flags_rd
    && !flags_q[`SBLEF_BIT_RX_BLOCK] |=> !flags_q[`SBLEF_BIT_RX_BLOCK])
    else $error("receive flag set during self-ID phase");

  chk_ack_flag : assert property (@(posedge sys_clk) // [RULE5]
    disable iff (!reset_n)
    state_q == TX_WAIT_ACK && (ack_valid_bit || tmo_hit)
    |=> flags_q[`SBLEF_BIT_ACK_RCV])
    else $error("ack or timeout did not set the ack flag");

  chk_irq_masked : assert property (@(posedge sys_clk) // [RULE6]
    disable iff (!reset_n)
    ##1 irq_q == |($past(flags_q) & $past(mask_q)))
    else $error("interrupt does not follow masked flags");

  chk_bad_first : assert property (@(posedge sys_clk) // [RULE8]
    disable iff (!reset_n)
    state_q == TX_IDLE && async_pkt_ready && !first_quadlet_port
    |=> state_q == TX_ERROR && flags_q[`SBLEF_BIT_ASYNC_FMT])
    else $error("bad first quadlet not caught");

  chk_err_lockout : assert property (@(posedge sys_clk) // [RULE10]
    disable iff (!reset_n)
    state_q == TX_ERROR && !flush_wr |=> state_q == TX_ERROR
    ##0 !async_send_q && !async_arb_req_q)
    else $error("async activity during error state");

  chk_iso_free : assert property (@(posedge sys_clk) // [RULE11]
    disable iff (!reset_n)
    iso_pkt_ready |=> iso_tx_start_q)
    else $error("iso start blocked");

  chk_busy_ack : assert property (@(posedge sys_clk) // [RULE12]
    disable iff (!reset_n)
    rx_addressed && queue_overflow
    |=> busy_ack_q && flags_q[`SBLEF_BIT_BUSY_ACK])
    else $error("overflow without busy ack");

  chk_hdr_discard : assert property (@(posedge sys_clk) // [RULE13]
    disable iff (!reset_n)
    rx_hdr_crc_err && rx_maybe_ours
    |=> rx_discard_q && flags_q[`SBLEF_BIT_HDR_CRC])
    else $error("header error packet kept");

  chk_sticky_hold : assert property (@(posedge sys_clk) // [RULE18]
    disable iff (!reset_n)
    flags_q[`SBLEF_BIT_TCODE] && !flags_rd ##1 !flags_rd
    |-> flags_q[`SBLEF_BIT_TCODE] [*2])
    else $error("flag cleared itself");

endmodule : sblef_event_flags

//--- design/sblef_pkg.sv
/*
  Types of the link event flag block.
  Assumes sblef_consts.svh supplies all numeric constants.
*/
package sblef_pkg;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_ARB,
    TX_SEND,
    TX_WAIT_ACK,
    TX_ERROR
  } sblef_tx_state_e;

  typedef logic [31:0] sblef_word_t;

endpackage : sblef_pkg

//--- sim/sblef_event_flags_bench.sv
/*
  Self-checking bench of the link event flags: register port through
  the host model, datapath events pulsed directly. Assumes short
  overrun and ack timeout parameters.
*/
`timescale 1ns/1ps
`include "sblef_consts.svh"

`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) begin \
      fails++; \
      $display("unexpected %0t: got %h exp %h", $time, (g), (e)); \
    end \
  end
`define WT(c) for (int j = 0; j < 40 && !(c); j++) @(posedge sys_clk);

module sblef_event_flags_bench;
  localparam int CYC_OVR = 20;
  localparam int ACK_TMO = 8;
  logic        sys_clk, reset_n, reg_wr, reg_rd, irq_q;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, rd_d;
  logic        async_pkt_ready, first_quadlet_port, bus_idle, arb_won;
  logic        iso_pkt_ready, iso_cycle_active, bus_reset_active;
  logic        async_broadcast, rx_trigger_hit;
  logic        async_arb_req_q, async_send_q, async_queue_flush_q;
  logic        iso_tx_start_q, busy_ack_q, rx_discard_q;
  logic [12:0] pv;
  int          fails, tests_run, cyc;
  logic [12:0] pat [6] = '{13'h0001, 13'h0006, 13'h0008, 13'h0010,
                           13'h0060, 13'h0180};
  int          bitpos [6] = '{6, 7, 11, 16, 15, 14};

  sblef_host_model i_host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q)
  );

  // Single-cycle events come from the pulse vector pv
  sblef_event_flags #(.CYC_OVR_CYC(CYC_OVR), .ACK_TMO_CYC(ACK_TMO)) i_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .irq_q(irq_q),
    .async_pkt_ready(async_pkt_ready),
    .first_quadlet_port(first_quadlet_port),
    .async_broadcast(async_broadcast),
    .bus_idle(bus_idle), .arb_won(arb_won), .send_done(pv[10]),
    .async_underflow(pv[9]), .ack_valid_bit(pv[11]),
    .async_arb_req_q(async_arb_req_q), .async_send_q(async_send_q),
    .async_queue_flush_q(async_queue_flush_q),
    .iso_pkt_ready(iso_pkt_ready), .iso_bad_data(pv[3]),
    .tx_bad_tcode(pv[4]), .iso_cycle_active(iso_cycle_active),
    .iso_tx_start_q(iso_tx_start_q), .rx_packet_end(pv[0]),
    .rx_trigger_hit(rx_trigger_hit), .rx_quadlet_write(pv[1]),
    .rx_dest_reset_start(pv[2]), .rx_addressed(pv[7]),
    .queue_overflow(pv[8]), .rx_hdr_crc_err(pv[5]),
    .rx_maybe_ours(pv[6]), .bus_reset_active(bus_reset_active),
    .bus_reset_done(pv[12]), .busy_ack_q(busy_ack_q),
    .rx_discard_q(rx_discard_q)
  );

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task end_of_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_of_test

  // Hang guard, well above the few hundred cycles the run needs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      end_of_test();
    end
  end

  task read_check(input logic [7:0] a, input logic [31:0] e);
    i_host.host_read(a, rd_d);
    `CHK(rd_d, e)
  endtask : read_check

  task ev(input logic [12:0] p);
    @(posedge sys_clk);
    pv <= p;
    @(posedge sys_clk);
    pv <= '0;
    #1;
    `CHK(busy_ack_q, p[7] & p[8])
    `CHK(rx_discard_q, p[5] & p[6])
  endtask : ev

  task send_pkt(input logic [12:0] p);
    `WT(async_arb_req_q)
    async_pkt_ready <= 1'h0;
    arb_won         <= 1'h1;
    `WT(async_send_q)
    arb_won         <= 1'h0;
    `CHK(async_send_q, 1'h1)
    ev(p);
  endtask : send_pkt

  initial begin
    reset_n = 1'h0;
    pv = '0;
    async_pkt_ready = 1'h0;
    first_quadlet_port = 1'h0;
    bus_idle = 1'h0;
    arb_won = 1'h0;
    iso_pkt_ready = 1'h0;
    iso_cycle_active = 1'h0;
    bus_reset_active = 1'h0;
    fails = 0;
    tests_run = 0;
    async_broadcast = 1'h0;
    rx_trigger_hit = 1'h0;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0020);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0000);
    read_check(`SBLEF_OFS_MASK, `SBLEF_RST_MASK);
    read_check(`SBLEF_OFS_CTRL, `SBLEF_RST_CTRL);
    read_check(8'h20, 32'h0000_0000);
    i_host.host_write(`SBLEF_OFS_MASK, 32'hFFFF_FFFF);
    read_check(`SBLEF_OFS_MASK, `SBLEF_FLAGS_IMPL);
    i_host.host_write(`SBLEF_OFS_MASK, 32'h0000_0000);
    // Flags must still be set several cycles after the pulse
    for (int k = 0; k < 6; k++) begin
      ev(pat[k]);
      repeat (4) @(posedge sys_clk);
      read_check(`SBLEF_OFS_FLAGS, 32'h1 << bitpos[k]);
    end
    i_host.host_write(`SBLEF_OFS_MASK, 32'h0000_0080);
    ev(13'h0006);
    repeat (3) @(posedge sys_clk);
    #1 `CHK(irq_q, 1'h1)
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0080);
    repeat (3) @(posedge sys_clk);
    #1 `CHK(irq_q, 1'h0)
    ev(13'h0008);
    repeat (3) @(posedge sys_clk);
    #1 `CHK(irq_q, 1'h0)
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0800);
    @(posedge sys_clk);
    bus_reset_active <= 1'h1;
    ev(13'h0001);
    repeat (3) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0000);
    ev(13'h1000);
    @(posedge sys_clk);
    bus_reset_active <= 1'h0;
    repeat (3) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0050);
    i_host.host_write(`SBLEF_OFS_CTRL, 32'h0000_0000);
    @(posedge sys_clk);
    bus_reset_active <= 1'h1;
    ev(13'h1000);
    @(posedge sys_clk);
    bus_reset_active <= 1'h0;
    repeat (3) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0000);
    // Trigger hits count as blocks only with splitting on
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      rx_trigger_hit <= 1'h1;
      @(posedge sys_clk);
      rx_trigger_hit <= 1'h0;
      repeat (2) @(posedge sys_clk);
      read_check(`SBLEF_OFS_FLAGS, k ? 32'h0000_0040 : 32'h0);
      i_host.host_write(`SBLEF_OFS_CTRL, 32'h0000_0004);
    end
    // First send gets no ack and must rearbitrate
    @(posedge sys_clk);
    first_quadlet_port <= 1'h1;
    async_pkt_ready    <= 1'h1;
    bus_idle           <= 1'h1;
    send_pkt(13'h0400);
    repeat (ACK_TMO + 4) @(posedge sys_clk);
    #1 `CHK(async_arb_req_q, 1'h1)
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0100);
    send_pkt(13'h0400);
    ev(13'h0800);
    repeat (3) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0120);
    // A broadcast send waits for no ack and never rearbitrates
    @(posedge sys_clk);
    async_broadcast <= 1'h1;
    async_pkt_ready <= 1'h1;
    send_pkt(13'h0400);
    repeat (ACK_TMO + 4) @(posedge sys_clk);
    #1 `CHK(async_arb_req_q, 1'h0)
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0020);
    @(posedge sys_clk);
    async_broadcast    <= 1'h0;
    first_quadlet_port <= 1'h0;
    async_pkt_ready    <= 1'h1;
    repeat (4) @(posedge sys_clk);
    #1 `CHK(async_arb_req_q, 1'h0)
    read_check(`SBLEF_OFS_STATUS, 32'h0000_0001);
    @(posedge sys_clk);
    async_pkt_ready <= 1'h0;
    iso_pkt_ready   <= 1'h1;
    @(posedge sys_clk);
    iso_pkt_ready   <= 1'h0;
    #1 `CHK(iso_tx_start_q, 1'h1)
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_1000);
    i_host.host_write(`SBLEF_OFS_FLUSH, 32'h0000_0001);
    #1 `CHK(async_queue_flush_q, 1'h1)
    read_check(`SBLEF_OFS_STATUS, 32'h0000_0002);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0020);
    @(posedge sys_clk);
    first_quadlet_port <= 1'h1;
    async_pkt_ready    <= 1'h1;
    send_pkt(13'h0200);
    read_check(`SBLEF_OFS_STATUS, 32'h0000_0001);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_1000);
    i_host.host_write(`SBLEF_OFS_FLUSH, 32'h0000_0001);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0020);
    // A cycle of exactly the limit must not count as overrun
    @(posedge sys_clk);
    iso_cycle_active <= 1'h1;
    repeat (CYC_OVR) @(posedge sys_clk);
    iso_cycle_active <= 1'h0;
    repeat (3) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0000_0000);
    @(posedge sys_clk);
    iso_cycle_active <= 1'h1;
    repeat (CYC_OVR + 1) @(posedge sys_clk);
    iso_cycle_active <= 1'h0;
    repeat (3) @(posedge sys_clk);
    read_check(`SBLEF_OFS_FLAGS, 32'h0008_0000);
    end_of_test();
  end
endmodule : sblef_event_flags_bench

//--- sim/sblef_host_model.sv
/*
  Host processor model: drives the register port with single-cycle
  write and read strobes. Assumes reads return data one cycle later.
*/
`timescale 1ns/1ps
`include "sblef_consts.svh"

module sblef_host_model (
  // Clock
  input  wire logic                     sys_clk,
  // Register port
  output logic      [`SBLEF_ADDR_W-1:0] reg_addr,
  output logic      [31:0]              reg_wdata,
  output logic                          reg_wr,
  output logic                          reg_rd,
  input  wire logic [31:0]              reg_rdata_q
);
  initial begin
    reg_addr  = '0;
    reg_wdata = '0;
    reg_wr    = 1'h0;
    reg_rd    = 1'h0;
  end

  task host_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'h1;
    @(posedge sys_clk);
    reg_wr    <= 1'h0;
  endtask : host_write

  // Data is valid only in the cycle after the strobe
  task host_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'h1;
    @(posedge sys_clk);
    reg_rd   <= 1'h0;
    @(negedge sys_clk);
    d = reg_rdata_q;
    @(posedge sys_clk);
  endtask : host_read
endmodule : sblef_host_model
